// *** hw/loop_channel_output_control.sv ***
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "loop_channel_select_button_defs.svh"

// Function
// RL1 - Green inactive: disconnect-enabled channel calls exactly as normally programmed.
// RL2 - Disconnect on, green active: countdown starts at each detection end.
// RL3 - Countdown expiring before next detection suppresses calls until green ends.
// RL4 - Disconnect type off: extension still times, call held until disconnect.
// RL5 - Disconnect type on: no extension, call follows occupancy until disconnect.
// RL6 - Detection before expiry gives a call and reloads the timer.
// RL7 - Each green start times an initial gap from the disconnect timer.
// RL8 - Active-low green aborts delay timing and gates the green-dependent features.
// RL9 - Reset pin held low 30 ms by controller resets every channel.
// RL10 - Changing the noise filter disable setting resets the whole detector.
// RL11 - Holding channel select three seconds resets only the selected channel.
// RL12 - Changing sensitivity or loop frequency resets that channel only.
// RL13 - Call output forced on for any loop failure or power loss.
// RL14 - Status steady on normally, off on failure, coded blinks per fault.
// RL15 - Inductance out of range or 25 percent jump enters fail-safe at once.
// RL16 - Fault type low for drop or short, high for rise or open.
// RL17 - Loop failure latches a three-per-second LED flash until reset.
// RL18 - A healed loop clears the fault message and resumes normal behaviour.
// RL19 - Each loop failure counts; cleared by reset, readable by software.
// RL20 - Backlight on at any press, off 15 minutes after the last.
// RL21 - Operational two seconds after reset; full sensitivity after 30 seconds.
// RL22 - Channel LED shows call, delay, extension, pending and failed loop.
// RL23 - Noise filter setting change keeps fault count and fault indication.
// RL24 - Disconnect timer reloads programmed extension, decrements on a fixed tick.
module loop_channel_output_control
  import loop_channel_select_button_pkg::*;
#(
  parameter int LIGHT_MS = `LIGHT_MS,
  parameter int SETTLE_MS = `SETTLE_MS,
  parameter int TICK_CYC = `TICK_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extResetN,
  input wire logic phaseGreenN,
  input wire logic loopOccupied,
  input wire logic delayTiming,
  input wire logic pendingState,
  input wire logic loopOpen,
  input wire logic loopShort,
  input wire logic loopRise,
  input wire logic loopDrop,
  input wire logic detectorFail,
  input wire logic buttonPressed,
  input wire logic channelSelectButton,
  input wire logic channelSelected,
  output logic callOut,
  output logic statusOut,
  output logic ledOut,
  output logic backlightOut,
  output logic faultTypeHigh,
  output logic faultTypeLow,
  output logic loopFailMsg,
  output logic channelResetOut,
  output logic detectorResetOut,
  output logic operational,
  output logic fullSensitivity,
  output logic delayAbort
);

  localparam int RES_CYC = `EXT_RES_MS;

  // The prescaler is 20 bits wide and the tick must be at least one cycle
  if (TICK_CYC < 1 || TICK_CYC > 1048576) begin : g_bad_tick
    $error("loop_channel_output_control: TICK_CYC out of range");
  end
  // The backlight counter is 20 bits wide
  if (LIGHT_MS < 1 || LIGHT_MS > 1048575) begin : g_bad_light
    $error("loop_channel_output_control: LIGHT_MS out of range");
  end
  // Full sensitivity cannot come before the channel is operational
  if (SETTLE_MS < `TUNE_MS || SETTLE_MS > 65535) begin : g_bad_settle
    $error("loop_channel_output_control: SETTLE_MS out of range");
  end

  typedef struct packed {
    logic [2:0] ctrl;
    logic [7:0] extTime;
    logic [7:0] chanSet;
    logic [15:0] failCount;
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic [5:0] syncC;
    logic [5:0] syncD;
    logic [5:0] syncE;
    logic [4:0] syncF;
    logic extRst;
    logic [19:0] prescale;
    logic tick;
    disc_t disc;
    logic [15:0] discCnt;
    logic greenPrev;
    logic occPrev;
    logic [7:0] resLowMs;
    logic [11:0] holdMs;
    logic [19:0] lightMs;
    logic [15:0] upMs;
    logic [7:0] blinkMs;
    logic [7:0] flashMs;
    logic flashPhase;
    logic failLatched;
    logic faultPrev;
    logic chanRst;
    logic detRst;
    logic [31:0] rdata;
  } state_t;

  state_t q, d;

  logic greenS, occS, extRstS, openS, shortS, riseS, dropS, detFailS, btnS, selBtnS, selS;
  logic anyFault, access, wr, green;
  logic [15:0] extCycMs;
  logic [7:0] offMs;
  fault_t fault;

  assign greenS = !q.syncA[1];
  assign occS = q.syncB[1];
  assign extRstS = q.syncC[5];
  assign openS = q.syncD[5];
  assign shortS = q.syncC[4];
  assign riseS = q.syncC[3];
  assign dropS = q.syncC[2];
  assign detFailS = q.syncC[1];
  assign btnS = q.syncC[0];
  assign selBtnS = q.syncD[4];
  assign selS = q.syncD[3];
  assign green = greenS;
  assign anyFault = openS | shortS | riseS | dropS;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign extCycMs = 16'(q.extTime) * 16'(`EXT_UNIT_MS);

  // Several faults can stand at once; the first in this order names the fault
  always_comb begin
    priority case (1'b1)
      openS: fault = FAULT_OPEN;
      shortS: fault = FAULT_SHORT;
      riseS: fault = FAULT_RISE;
      dropS: fault = FAULT_DROP;
      detFailS: fault = FAULT_DETECTOR;
      default: fault = FAULT_NONE;
    endcase
    unique case (fault)
      FAULT_OPEN: offMs = 8'(`STAT_OFF_OPEN_MS);
      FAULT_SHORT: offMs = 8'(`STAT_OFF_SHORT_MS);
      default: offMs = 8'(`STAT_OFF_CHANGE_MS);
    endcase
  end

  always_comb begin
    d = q;
    d.syncA = {q.syncA[0], phaseGreenN};
    d.syncB = {q.syncB[0], loopOccupied};
    // Every pin passes two flops; only the second stage is read by logic
    d.syncE = {extResetN, loopShort, loopRise, loopDrop, detectorFail, buttonPressed};
    d.syncC = q.syncE;
    d.syncF = {loopOpen, channelSelectButton, channelSelected, delayTiming, pendingState};
    d.syncD = {q.syncF, 1'b0};
    d.extRst = 1'b0;
    d.chanRst = 1'b0;
    d.detRst = 1'b0;
    d.tick = 1'b0;
    if (q.prescale == 20'(TICK_CYC - 1)) begin // [RL24]
      d.prescale = 20'h0;
      d.tick = 1'b1;
    end else begin
      d.prescale = q.prescale + 20'h1;
    end
    d.greenPrev = green;
    d.occPrev = occS;
    // Register interface, zero-wait
    if (wr) begin
      unique case (paddr)
        `OFS_CTRL: begin
          if (pwdata[`CTRL_NOISE_DIS] != q.ctrl[`CTRL_NOISE_DIS]) begin
            d.detRst = 1'b1; // [RL10] [RL23]
          end
          if (pwdata[`CTRL_CHANNEL_SELECT_BUTTON_RESET]) begin
            d.chanRst = 1'b1;
          end
          d.ctrl = pwdata[2:0];
        end
        `OFS_EXT: d.extTime = pwdata[7:0]; // [RL24]
        `OFS_CHSET: begin
          if (pwdata[7:0] != q.chanSet) begin
            d.chanRst = 1'b1; // [RL12]
          end
          d.chanSet = pwdata[7:0];
        end
        default: ;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `OFS_CTRL: d.rdata = {29'h0, q.ctrl};
        `OFS_EXT: d.rdata = {24'h0, q.extTime};
        `OFS_CHSET: d.rdata = {24'h0, q.chanSet};
        `OFS_STATUS: d.rdata = {24'h0, q.disc, 1'b0, fault};
        `OFS_FAILCNT: d.rdata = {16'h0, q.failCount}; // [RL19]
        `OFS_LIGHT: d.rdata = {31'h0, backlightOut};
        default: d.rdata = 32'h0;
      endcase
    end
    if (q.tick) begin
      // External reset qualified by 30 ms of low level
      if (!extRstS) begin
        if (q.resLowMs == 8'(RES_CYC - 1)) begin
          d.detRst = 1'b1; // [RL9]
          d.extRst = 1'b1;
        end
        if (q.resLowMs != 8'hFF) begin
          d.resLowMs = q.resLowMs + 8'h1;
        end
      end else begin
        d.resLowMs = 8'h0;
      end
      if (selBtnS && selS) begin
        if (q.holdMs == 12'(`BTN_HOLD_MS - 1)) begin
          d.chanRst = 1'b1; // [RL11]
        end
        if (q.holdMs != 12'hFFF) begin
          d.holdMs = q.holdMs + 12'h1;
        end
      end else begin
        d.holdMs = 12'h0;
      end
      if (btnS) begin
        d.lightMs = 20'(LIGHT_MS); // [RL20]
      end else if (q.lightMs != 20'h0) begin
        d.lightMs = q.lightMs - 20'h1;
      end
      if (q.upMs != 16'(SETTLE_MS)) begin
        d.upMs = q.upMs + 16'h1; // [RL21]
      end
      if (q.flashMs == 8'(`FLASH_HALF_MS - 1)) begin
        d.flashMs = 8'h0;
        d.flashPhase = !q.flashPhase; // [RL17]
      end else begin
        d.flashMs = q.flashMs + 8'h1;
      end
      if (q.blinkMs >= 8'(`STAT_ON_MS) + offMs - 8'h1) begin
        d.blinkMs = 8'h0;
      end else begin
        d.blinkMs = q.blinkMs + 8'h1;
      end
    end
    // Fault monitor
    d.faultPrev = anyFault;
    if (anyFault && !q.faultPrev) begin
      d.failLatched = 1'b1; // [RL17]
      d.failCount = q.failCount + 16'h1; // [RL19]
    end
    // Disconnect state machine
    unique case (q.disc)
      DISC_IDLE: begin
        if (green && !q.greenPrev && q.ctrl[`CTRL_DISC_EN]) begin
          d.disc = DISC_COUNTING; // [RL7]
          d.discCnt = extCycMs;
        end
      end
      DISC_OCCUPIED: begin
        if (!occS) begin
          d.disc = DISC_COUNTING; // [RL2]
          d.discCnt = extCycMs;
        end
      end
      DISC_COUNTING: begin
        if (occS) begin
          d.disc = DISC_OCCUPIED; // [RL6]
          d.discCnt = extCycMs;
        end else if (q.discCnt == 16'h0) begin
          d.disc = DISC_CUT; // [RL3]
        end else if (q.tick) begin
          d.discCnt = q.discCnt - 16'h1;
        end
      end
      DISC_CUT: ;
    endcase
    if (!green || !q.ctrl[`CTRL_DISC_EN]) begin
      d.disc = DISC_IDLE; // [RL1] [RL8]
      d.discCnt = 16'h0;
    end
    if (q.chanRst || q.detRst) begin
      d.disc = DISC_IDLE;
      d.discCnt = 16'h0;
      d.upMs = 16'h0;
      d.blinkMs = 8'h0;
    end
    // A noise filter change alone keeps count and latch; pin and channel resets clear them
    if (q.chanRst || q.extRst) begin // [RL9] [RL23]
      // A failure that starts in the clearing cycle still counts and latches
      d.failCount = (anyFault && !q.faultPrev) ? 16'h1 : 16'h0; // [RL19]
      d.failLatched = anyFault; // [RL17]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ctrl <= 3'(`RST_CTRL);
      q.extTime <= `RST_EXT;
      q.disc <= DISC_IDLE;
      q.syncA <= 2'h3;
      q.syncC <= 6'h20;
      q.syncE <= 6'h20;
    end else begin
      q <= d;
    end
  end

  logic discOn, callNormal;
  assign discOn = q.ctrl[`CTRL_DISC_EN] && green;
  // Disconnect type on follows raw occupancy; off holds through the extension
  assign callNormal = occS || (!q.ctrl[`CTRL_DISC_TYPE] && q.disc == DISC_COUNTING);
  always_comb begin
    if (anyFault || detFailS) begin
      callOut = 1'b1; // [RL13] [RL15]
    end else if (!discOn) begin
      callOut = occS; // [RL1]
    end else if (q.disc == DISC_CUT) begin
      callOut = 1'b0; // [RL3]
    end else if (q.ctrl[`CTRL_DISC_TYPE]) begin
      callOut = occS; // [RL5]
    end else begin
      callOut = callNormal; // [RL4]
    end
  end

  always_comb begin
    unique case (fault)
      FAULT_NONE: statusOut = 1'b1; // [RL14]
      FAULT_DETECTOR: statusOut = 1'b0;
      default: statusOut = q.blinkMs < 8'(`STAT_ON_MS);
    endcase
  end

  assign ledOut = q.failLatched ? q.flashPhase
                : (callOut | q.syncD[2] | q.syncD[1]
                   | (q.disc == DISC_COUNTING && !q.ctrl[`CTRL_DISC_TYPE])); // [RL22]
  assign faultTypeHigh = openS | riseS; // [RL16]
  assign faultTypeLow = shortS | dropS; // [RL16]
  assign loopFailMsg = anyFault; // [RL18]
  assign delayAbort = green; // [RL8]
  assign channelResetOut = q.chanRst;
  assign detectorResetOut = q.detRst;
  assign backlightOut = q.lightMs != 20'h0;
  assign operational = q.upMs >= 16'(`TUNE_MS); // [RL21]
  assign fullSensitivity = q.upMs == 16'(SETTLE_MS);
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = access && paddr > `OFS_LIGHT;

endmodule

// *** include/loop_channel_select_button_defs.svh ***
`ifndef LOOP_CHANNEL_SELECT_BUTTON_DEFS_SVH
`define LOOP_CHANNEL_SELECT_BUTTON_DEFS_SVH

// APB register byte offsets
`define OFS_CTRL 12'h000
`define OFS_EXT 12'h004
`define OFS_CHSET 12'h008
`define OFS_STATUS 12'h00C
`define OFS_FAILCNT 12'h010
`define OFS_LIGHT 12'h014

// Control register field positions
`define CTRL_DISC_EN 0
`define CTRL_DISC_TYPE 1
`define CTRL_NOISE_DIS 2
`define CTRL_CHANNEL_SELECT_BUTTON_RESET 3

// Reset values
`define RST_CTRL 4'h0
`define RST_EXT 8'h00

// Times in their own units and derived cycle counts at 100 MHz
`define CLK_HZ 100000000
`define TICK_MS 1
`define TICK_CYC ((`CLK_HZ / 1000) * `TICK_MS)
`define EXT_UNIT_MS 100
`define EXT_RES_MS 30
`define STAT_ON_MS 50
`define STAT_OFF_OPEN_MS 50
`define STAT_OFF_SHORT_MS 100
`define STAT_OFF_CHANGE_MS 150
`define FLASH_HALF_MS 167
`define BTN_HOLD_MS 3000
`define LIGHT_MS 900000
`define TUNE_MS 2000
`define SETTLE_MS 30000

`endif

// *** include/loop_channel_select_button_pkg.sv ***
package loop_channel_select_button_pkg;
  typedef enum logic [2:0] {
    FAULT_NONE = 3'h0,
    FAULT_OPEN = 3'h1,
    FAULT_SHORT = 3'h2,
    FAULT_RISE = 3'h3,
    FAULT_DROP = 3'h4,
    FAULT_DETECTOR = 3'h5
  } fault_t;

  typedef enum logic [3:0] {
    DISC_IDLE = 4'b0001,
    DISC_OCCUPIED = 4'b0010,
    DISC_COUNTING = 4'b0100,
    DISC_CUT = 4'b1000
  } disc_t;
endpackage

// *** tb/loop_ctrl_model.sv ***
`timescale 1ns/100ps
module loop_ctrl_model #(
  parameter int TICK_CYC = 10
) (
  input wire logic clock,
  input wire logic greenReq,
  input wire logic resetReq,
  output logic phaseGreenN,
  output logic extResetN
);
  int holdCnt = 0;
  initial begin
    phaseGreenN = 1'b1;
    extResetN = 1'b1;
  end
  always @(posedge clock) begin
    phaseGreenN <= !greenReq; // Green is signalled by a low level
    // Stretched to a full 30 ms so a short request still resets reliably
    if (resetReq) holdCnt <= 30 * TICK_CYC;
    else if (holdCnt > 0) holdCnt <= holdCnt - 1;
    extResetN <= !(resetReq || holdCnt > 1);
  end
endmodule

// *** tb/loop_channel_output_control_checker.sv ***
`timescale 1ns/100ps
module loop_channel_output_control_checker #(
  parameter int TICK_CYC = 10
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic phaseGreenN,
  input wire logic loopOpen,
  input wire logic loopShort,
  input wire logic loopRise,
  input wire logic loopDrop,
  input wire logic detectorFail,
  input wire logic callOut,
  input wire logic statusOut,
  input wire logic faultTypeHigh,
  input wire logic faultTypeLow,
  input wire logic loopFailMsg,
  input wire logic channelResetOut,
  input wire logic detectorResetOut,
  input wire logic delayAbort
);
  localparam int ON_CYC = 50 * TICK_CYC;
  logic [15:0] hiCnt_q;
  logic [15:0] openAge_q;
  logic anyFault;
  assign anyFault = loopOpen | loopShort | loopRise | loopDrop | detectorFail;
  // Saturating age keeps the blink check away from the partial first pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hiCnt_q <= 16'h0;
      openAge_q <= 16'h0;
    end else begin
      hiCnt_q <= statusOut ? hiCnt_q + 16'h1 : 16'h0;
      openAge_q <= !loopOpen ? 16'h0 : (&openAge_q ? openAge_q : openAge_q + 16'h1);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_fault_call: assert property (anyFault[*4] |-> callOut)
    else $error("call not forced on fault");
  chk_type_high: assert property (
    (loopOpen & !loopShort & !loopDrop)[*4] |-> faultTypeHigh)
    else $error("open loop not shown high");
  chk_type_low: assert property (
    (loopShort & !loopOpen & !loopRise)[*4] |-> faultTypeLow)
    else $error("short loop not shown low");
  chk_fail_msg: assert property (
    (loopOpen | loopShort | loopRise | loopDrop)[*4] |-> loopFailMsg)
    else $error("loop fail message missing");
  chk_heal_clear: assert property ((!anyFault)[*4] |-> !loopFailMsg)
    else $error("fail message stays after heal");
  chk_status_dead: assert property (detectorFail[*4] |-> !statusOut)
    else $error("status on during detector failure");
  chk_blink_on: assert property ($fell(statusOut) && openAge_q > 16'd2000 |->
    hiCnt_q >= ON_CYC - 1 && hiCnt_q <= ON_CYC + 1) else $error("blink on time wrong");
  chk_green_abort: assert property ((!phaseGreenN)[*3] |-> delayAbort)
    else $error("delay not aborted in green");
  chk_channel_select_button_reset: assert property (psel && penable && pwrite && paddr == 12'h000 && pwdata[3]
    |-> ##[0:3] channelResetOut) else $error("channel reset pulse missing");
  chk_unmapped_read: assert property (psel && penable && !pwrite && paddr > 12'h014
    |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  cover property ($rose(loopFailMsg));
  cover property ($fell(callOut) && !phaseGreenN);
  cover property ($rose(detectorResetOut));
endmodule
bind loop_channel_output_control loop_channel_output_control_checker #(.TICK_CYC(TICK_CYC)) chk (
  .clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .phaseGreenN,
  .loopOpen, .loopShort, .loopRise, .loopDrop, .detectorFail, .callOut, .statusOut,
  .faultTypeHigh, .faultTypeLow, .loopFailMsg, .channelResetOut, .detectorResetOut, .delayAbort);

// *** tb/loop_channel_output_control_bench.sv ***
`timescale 1ns/100ps
module loop_channel_output_control_bench;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, greenReq, resetReq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic extResetN, phaseGreenN, loopOccupied, delayTiming, pendingState, detectorFail;
  logic loopOpen, loopShort, loopRise, loopDrop, buttonPressed, channelSelectButton;
  logic channelSelected, callOut, statusOut, ledOut, backlightOut, faultTypeHigh, faultTypeLow;
  logic loopFailMsg, channelResetOut, detectorResetOut, operational, fullSensitivity, delayAbort;
  logic chanSeen, detSeen;
  int err_count, check_count, expFail, n;
  loop_channel_output_control #(.LIGHT_MS(20), .SETTLE_MS(2100), .TICK_CYC(10)) uut (.clock,
    .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .extResetN,
    .phaseGreenN, .loopOccupied, .delayTiming, .pendingState, .loopOpen, .loopShort, .loopRise,
    .loopDrop, .detectorFail, .buttonPressed, .channelSelectButton, .channelSelected, .callOut,
    .statusOut, .ledOut, .backlightOut, .faultTypeHigh, .faultTypeLow, .loopFailMsg,
    .channelResetOut, .detectorResetOut, .operational, .fullSensitivity, .delayAbort);
  loop_ctrl_model #(.TICK_CYC(10)) ctl (.clock, .greenReq, .resetReq, .phaseGreenN, .extResetN);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (channelResetOut === 1'b1) chanSeen <= 1'b1;
    if (detectorResetOut === 1'b1) detSeen <= 1'b1;
  end
  task automatic test_done();
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    #(900000);
    err_count++;
    test_done();
  end
  initial begin
    seed = 32'hd99b120d;
    {psel, penable, pwrite, paddr, pwdata, rst_n, greenReq, resetReq} = '0;
    {loopOccupied, delayTiming, pendingState, detectorFail, loopOpen, loopShort} = '0;
    {loopRise, loopDrop, buttonPressed, channelSelectButton, channelSelected} = '0;
    {chanSeen, detSeen, err_count, check_count, expFail} = '0;
    cyc(6);
    rst_n <= 1'b1;
    apb(0, 12'h000, 0);
    check("ctrl", rd, 0);
    apb(0, 12'h040, 0);
    check("unmapped", {rd[30:0], er}, 1);
    apb(1, 12'h004, 1);
    apb(1, 12'h000, 1);
    apb(0, 12'h004, 0);
    check("ext", rd, 1);
    loopOccupied <= 1'b1;
    cyc(20);
    check("call", callOut, 1);
    loopOccupied <= 1'b0;
    cyc(1300);
    check("call", callOut, 0);
    greenReq <= 1'b1;
    cyc(500);
    check("gapcall", callOut, 1);
    cyc(700);
    check("gapend", callOut, 0);
    loopOccupied <= 1'b1;
    cyc(20);
    check("cut", callOut, 0);
    {loopOccupied, greenReq} <= 2'b00;
    cyc(10);
    loopOccupied <= 1'b1;
    cyc(10);
    check("uncut", callOut, 1);
    loopOccupied <= 1'b0;
    cyc(1300);
    greenReq <= 1'b1;
    cyc(600);
    loopOccupied <= 1'b1;
    cyc(10);
    check("newcall", callOut, 1);
    loopOccupied <= 1'b0;
    cyc(900);
    check("reload", callOut, 1);
    cyc(300);
    check("expire", callOut, 0);
    greenReq <= 1'b0;
    apb(1, 12'h000, 3);
    greenReq <= 1'b1;
    cyc(20);
    loopOccupied <= 1'b1;
    cyc(20);
    check("follow", callOut, 1);
    loopOccupied <= 1'b0;
    cyc(10);
    check("follow", callOut, 0);
    greenReq <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      {delayTiming, pendingState} <= 2'b01 << k;
      cyc(5);
      check("led", ledOut, 1);
    end
    {delayTiming, pendingState} <= 2'b00;
    for (int k = 0; k < 4; k++) begin
      {loopOpen, loopShort, loopRise, loopDrop} <= 4'b1000 >> k;
      cyc(2500);
      check("failcall", callOut, 1);
      check("ftype", {faultTypeHigh, faultTypeLow}, (k % 2) ? 2'b01 : 2'b10);
      {loopOpen, loopShort, loopRise, loopDrop} <= 4'b0000;
      cyc(10);
      check("healed", loopFailMsg, 0);
      expFail++;
      apb(0, 12'h010, 0);
      check("failcnt", rd, expFail);
    end
    n = 0;
    repeat (3400) begin
      @(posedge clock);
      n += (ledOut === 1'b1);
    end
    check("flash", n > 500 && n < 2900, 1);
    detectorFail <= 1'b1;
    cyc(10);
    check("status", {statusOut, callOut}, 1);
    detectorFail <= 1'b0;
    apb(1, 12'h000, 7);
    cyc(5);
    check("detreset", detSeen, 1);
    apb(0, 12'h010, 0);
    check("keepcnt", rd, expFail);
    chanSeen <= 1'b0;
    apb(1, 12'h008, {$random(seed)} | 32'h1);
    cyc(5);
    check("chreset", chanSeen, 1);
    resetReq <= 1'b1;
    cyc(1);
    resetReq <= 1'b0;
    cyc(400);
    apb(0, 12'h010, 0);
    check("extreset", rd, 0);
    loopOpen <= 1'b1;
    cyc(20);
    loopOpen <= 1'b0;
    apb(1, 12'h000, 8);
    apb(0, 12'h010, 0);
    check("manreset", rd, 0);
    check("tuning", operational, 0);
    {chanSeen, channelSelected, channelSelectButton, buttonPressed} <= 4'b0111;
    cyc(150);
    check("light", backlightOut, 1);
    buttonPressed <= 1'b0;
    cyc(250);
    check("dark", backlightOut, 0);
    cyc(28700);
    check("hold", chanSeen, 0);
    check("ready", {operational, fullSensitivity}, 3);
    cyc(1300);
    check("hold", chanSeen, 1);
    test_done();
  end
endmodule
